// File: design/dll_lock_ctrl.sv
// Controller end: holds the DLL-disable pin low until power and clock are good, then counts
// the lock interval before letting accesses through.
// Assumes power_good_i and clk_good_i are synchronous to clk_i.
`timescale 1ns/1ps
// Notes on behaviour
// - Hold disable pin low during power-up
// - Release pin only after power, clock stable
// - Give 1024 stable cycles after release
// - Device locks after 1024 stable cycles
// - Device DLL references main input clock
// - No DLL use below 120 MHz
// - Clock instability needs 1024 cycles relock
module dll_lock_ctrl #(
	parameter int unsigned LOCK_CYCLES = dll_lock_pkg::LOCK_CYCLES,
	parameter int unsigned CLK_MHZ     = dll_lock_pkg::CLK_MHZ
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	// System status
	input  wire logic power_good_i,
	input  wire logic clk_good_i,
	// User side
	output logic      lock_ready_o,
	output logic      relocking_o,
	// Link
	dll_lock_if.ctrl  link
);
	initial begin
		if (LOCK_CYCLES < 1 || LOCK_CYCLES >= (1 << dll_lock_pkg::CNT_W))
			$error("LOCK_CYCLES out of range");
		if (CLK_MHZ < dll_lock_pkg::DLL_MIN_MHZ)
			$error("clock below DLL minimum");
	end

	typedef enum logic [2:0] {
		ST_OFF  = 3'b001,
		ST_LOCK = 3'b010,
		ST_RUN  = 3'b100
	} ctrl_state_t;

	ctrl_state_t                       state;
	ctrl_state_t                       next_state;
	logic [dll_lock_pkg::CNT_W-1:0]    cnt;
	logic [dll_lock_pkg::CNT_W-1:0]    next_cnt;
	logic                              dis_n;
	logic                              next_dis_n;
	logic                              ready;
	logic                              next_ready;
	logic                              stable;
	logic                              next_stable;

	localparam logic [dll_lock_pkg::CNT_W-1:0] LAST = dll_lock_pkg::CNT_W'(LOCK_CYCLES - 1);

	always_comb begin
		next_state  = state;
		next_cnt    = cnt;
		next_dis_n  = dis_n;
		next_ready  = 1'b0;
		next_stable = clk_good_i;
		unique case (state)
			ST_OFF: begin
				next_dis_n = dll_lock_pkg::DLL_DIS_RESET;
				next_cnt   = '0;
				if (power_good_i && clk_good_i) begin
					next_dis_n = 1'b1;
					next_state = ST_LOCK;
				end
			end
			ST_LOCK: begin
				// A glitch restarts the interval, so a wrong-frequency lock is never trusted.
				if (!power_good_i) begin
					next_state = ST_OFF;
					next_dis_n = 1'b0;
				end else if (!clk_good_i) begin
					next_cnt = '0;
				end else if (cnt == LAST) begin
					next_state = ST_RUN;
					next_ready = 1'b1;
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			ST_RUN: begin
				next_ready = 1'b1;
				if (!power_good_i) begin
					next_state = ST_OFF;
					next_dis_n = 1'b0;
					next_ready = 1'b0;
				end else if (!clk_good_i) begin
					next_state = ST_LOCK;
					next_cnt   = '0;
					next_ready = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state  <= ST_OFF;
			cnt    <= '0;
			dis_n  <= 1'b0;
			ready  <= 1'b0;
			stable <= 1'b0;
		end else begin
			state  <= next_state;
			cnt    <= next_cnt;
			dis_n  <= next_dis_n;
			ready  <= next_ready;
			stable <= next_stable;
		end
	end

	assign link.dll_disable_n = dis_n;
	assign link.clk_stable    = stable;
	assign lock_ready_o       = ready;
	assign relocking_o        = (state == ST_LOCK);
endmodule : dll_lock_ctrl

// File: design/dll_lock_dev.sv
// Device end: models the DLL lock tracking of the memory, counting stable reference cycles.
// Assumes clk_i is the main input clock and the link is driven by the controller end.
`timescale 1ns/1ps
module dll_lock_dev #(
	parameter int unsigned LOCK_CYCLES = dll_lock_pkg::LOCK_CYCLES
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	// User side
	output logic      dll_locked_o,
	output logic      dll_on_o,
	// Link
	dll_lock_if.dev   link
);
	initial begin
		if (LOCK_CYCLES < 1 || LOCK_CYCLES >= (1 << dll_lock_pkg::CNT_W))
			$error("LOCK_CYCLES out of range");
	end

	localparam logic [dll_lock_pkg::CNT_W-1:0] LAST = dll_lock_pkg::CNT_W'(LOCK_CYCLES - 1);

	logic [dll_lock_pkg::CNT_W-1:0] cnt;
	logic [dll_lock_pkg::CNT_W-1:0] next_cnt;
	logic                           locked;
	logic                           next_locked;
	logic                           on;
	logic                           next_on;

	// The reference is clk_i itself; no other clock feeds the lock counter.
	always_comb begin
		next_on     = link.dll_disable_n;
		next_cnt    = cnt;
		next_locked = locked;
		if (!link.dll_disable_n || !link.clk_stable) begin
			next_cnt    = '0;
			next_locked = 1'b0;
		end else if (!locked) begin
			if (cnt == LAST)
				next_locked = 1'b1;
			else
				next_cnt = cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt    <= '0;
			locked <= 1'b0;
			on     <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			locked <= next_locked;
			on     <= next_on;
		end
	end

	assign dll_locked_o = locked;
	assign dll_on_o     = on;
endmodule : dll_lock_dev

// File: design/dll_lock_if.sv
// Link between the memory controller end and the memory device end.
// Assumes a single clock shared by both ends, supplied by the testbench.
`timescale 1ns/1ps
interface dll_lock_if;
	logic dll_disable_n;
	logic clk_stable;
	modport ctrl (output dll_disable_n, output clk_stable);
	modport dev  (input dll_disable_n, input clk_stable);
endinterface : dll_lock_if

// File: design/dll_lock_pkg.sv
// Shared constants for the power-up and clock-lock sequencing pair.
// Assumes both ends run on one 125 MHz clock that stands for the main input clock.
package dll_lock_pkg;
	localparam int unsigned LOCK_CYCLES     = 1024;
	localparam int unsigned CNT_W           = 11;
	localparam int unsigned CLK_MHZ         = 125;
	localparam int unsigned DLL_MIN_MHZ     = 120;
	localparam logic        DLL_DIS_RESET   = 1'b0;
endpackage : dll_lock_pkg

// File: verification/dll_lock_asserts.sv
// Checker on the link between the controller and device ends.
// Assumes it is instantiated beside the link interface in the bench top.
`timescale 1ns/1ps
module dll_lock_asserts (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic dll_disable_n,
	input wire logic clk_stable,
	input wire logic lock_ready,
	input wire logic dll_locked
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_rise; $rose(dll_disable_n) |-> clk_stable; endproperty
	a_rise: assert property (p_rise) else $error("pin rose without clock");
	property p_rst; $fell(sys_rst_i) |-> !dll_disable_n; endproperty
	a_rst: assert property (p_rst) else $error("pin high out of reset");
	property p_rdy_pin; lock_ready |-> dll_disable_n; endproperty
	a_rdy_pin: assert property (p_rdy_pin) else $error("ready with pin low");
	property p_rdy_clk; lock_ready |-> clk_stable; endproperty
	a_rdy_clk: assert property (p_rdy_clk) else $error("ready while clock unstable");
	property p_wait; $rose(dll_disable_n) |-> !lock_ready [*8]; endproperty
	a_wait: assert property (p_wait) else $error("ready before lock interval");
	property p_lck_pin; dll_locked |-> $past(dll_disable_n); endproperty
	a_lck_pin: assert property (p_lck_pin) else $error("locked with pin low");
	c_up: cover property ($rose(dll_disable_n));
	c_rdy: cover property ($rose(lock_ready));
	c_loss: cover property ($fell(clk_stable) && dll_disable_n);
	c_off: cover property ($fell(dll_disable_n));
endmodule : dll_lock_asserts

// File: verification/sram_dll_powerup_lock_tb.sv
// Bench joining both ends, compared every cycle with a cycle model.
// Assumes the design package and interface are compiled first.
`timescale 1ns/1ps
module sram_dll_powerup_lock_tb;
	localparam int unsigned LOCK = 8;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        power_good_i = 1'b0;
	logic        clk_good_i = 1'b0;
	logic        lock_ready_o;
	logic        relocking_o;
	logic        dll_locked_o;
	logic        dll_on_o;
	logic        m_pin = 1'b0;
	logic        m_rdy = 1'b0;
	logic        m_on = 1'b0;
	logic [31:0] seed = 32'hc1e1;
	logic        m_stb = 1'b0;
	logic        m_lck = 1'b0;
	int          m_dcnt = 0;
	int          m_cnt = 0;
	int          num_errors = 0;
	int          total_checks = 0;
	always #4 clk_i = ~clk_i;
	dll_lock_if dll_lock_if_i ();
	dll_lock_ctrl #(.LOCK_CYCLES(LOCK)) dll_lock_ctrl_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.power_good_i(power_good_i), .clk_good_i(clk_good_i), .lock_ready_o(lock_ready_o),
		.relocking_o(relocking_o), .link(dll_lock_if_i));
	dll_lock_dev #(.LOCK_CYCLES(LOCK)) dll_lock_dev_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.dll_locked_o(dll_locked_o), .dll_on_o(dll_on_o), .link(dll_lock_if_i));
	dll_lock_asserts dll_lock_asserts_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.dll_disable_n(dll_lock_if_i.dll_disable_n), .clk_stable(dll_lock_if_i.clk_stable),
		.lock_ready(lock_ready_o), .dll_locked(dll_locked_o));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic check(input string name, input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %b seen %b", name, exp, got);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// A clock loss while counting restarts the interval from zero.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			m_pin <= 1'b0;
			m_rdy <= 1'b0;
			m_on <= 1'b0;
			m_stb <= 1'b0;
			m_lck <= 1'b0;
			m_dcnt <= 0;
		end else begin
			m_on <= m_pin;
			m_stb <= clk_good_i;
			if (!m_pin || !m_stb) begin
				m_dcnt <= 0;
				m_lck <= 1'b0;
			end else if (!m_lck) begin
				if (m_dcnt == LOCK - 1) m_lck <= 1'b1;
				else m_dcnt <= m_dcnt + 1;
			end
			if (!power_good_i) begin
				m_pin <= 1'b0;
				m_rdy <= 1'b0;
			end else if (!m_pin) begin
				m_pin <= clk_good_i;
				m_cnt <= 0;
			end else if (!clk_good_i) begin
				m_cnt <= 0;
				m_rdy <= 1'b0;
			end else if (m_cnt < LOCK) begin
				m_cnt <= m_cnt + 1;
				m_rdy <= (m_cnt + 1 == LOCK);
			end
		end
	end
	always @(negedge clk_i) begin
		check("pin", dll_lock_if_i.dll_disable_n, m_pin);
		check("ready", lock_ready_o, m_rdy);
		check("relock", relocking_o, m_pin & ~m_rdy);
		check("dll_on", dll_on_o, m_on);
		check("stable", dll_lock_if_i.clk_stable, m_stb);
		check("dll_lock", dll_locked_o, m_lck);
	end
	initial begin
		repeat (10) @(posedge clk_i);
		#1 sys_rst_i = 1'b0;
		for (int i = 0; i < 60; i++) begin
			seed = xs(seed);
			power_good_i = (i % 20 == 19) ? 1'b0 : (seed[3:0] != 4'h0);
			clk_good_i = seed[7:4] > 4'h3;
			repeat (seed[10:8] * 4 + 1) @(posedge clk_i);
			#1;
		end
		power_good_i = 1'b1;
		clk_good_i = 1'b1;
		repeat (3 * LOCK) @(posedge clk_i);
		#1 check("locked", dll_locked_o, 1'b1);
		power_good_i = 1'b0;
		repeat (4) @(posedge clk_i);
		#1 check("unlocked", dll_locked_o, 1'b0);
		sys_rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1 sys_rst_i = 1'b0;
		repeat (4) @(posedge clk_i);
		report_and_stop();
	end
	initial begin
		#80000;
		num_errors++;
		report_and_stop();
	end
endmodule : sram_dll_powerup_lock_tb
